// File: dsa_pkg.sv
// package for the drive state machine and mailbox abort logic
// shared by the single design module dsa_top
package dsa_pkg;

   // ==========================================================
   // abort codes
   localparam logic [31:0] ABORT_NONE        = 32'h0000_0000;
   localparam logic [31:0] ABORT_TOGGLE      = 32'h0503_0000;
   localparam logic [31:0] ABORT_TIMEOUT     = 32'h0504_0000;
   localparam logic [31:0] ABORT_CMD_UNKNOWN = 32'h0504_0001;
   localparam logic [31:0] ABORT_SUB0_NZ     = 32'h0601_0003;
   localparam logic [31:0] ABORT_NO_COMPLETE = 32'h0601_0004;
   localparam logic [31:0] ABORT_NO_OBJECT   = 32'h0602_0000;
   localparam logic [31:0] ABORT_NOT_MAPPABLE= 32'h0604_0041;
   localparam logic [31:0] ABORT_MAP_EXCEEDS = 32'h0604_0042;
   localparam logic [31:0] ABORT_LEN         = 32'h0607_0010;
   localparam logic [31:0] ABORT_LEN_LONG    = 32'h0607_0012;
   localparam logic [31:0] ABORT_LEN_SHORT   = 32'h0607_0013;
   localparam logic [31:0] ABORT_NO_SUB      = 32'h0609_0011;
   localparam logic [31:0] ABORT_TOO_GREAT   = 32'h0609_0031;
   localparam logic [31:0] ABORT_TOO_SMALL   = 32'h0609_0032;
   localparam logic [31:0] ABORT_BELOW_MIN   = 32'h0609_0036;
   localparam logic [31:0] ABORT_GENERAL     = 32'h0800_0000;
   localparam logic [31:0] ABORT_LOCAL_CTRL  = 32'h0800_0021;
   localparam logic [31:0] ABORT_STATE       = 32'h0800_0022;

   // ==========================================================
   // object indices
   localparam logic [15:0] OBJ_COMMAND = 16'h6040;
   localparam logic [15:0] OBJ_STATUS  = 16'h6041;

   // ==========================================================
   // command word bit positions
   localparam int CMD_SWITCH_ON   = 0;
   localparam int CMD_EN_VOLTAGE  = 1;
   localparam int CMD_QUICK_STOP  = 2;
   localparam int CMD_EN_OPER     = 3;
   localparam int CMD_FAULT_RESET = 7;

   // ==========================================================
   // status word patterns
   localparam logic [15:0] STAT_NOT_READY  = 16'h0000;
   localparam logic [15:0] STAT_SW_ON_DIS  = 16'h0040;
   localparam logic [15:0] STAT_READY      = 16'h0021;
   localparam logic [15:0] STAT_SWITCHED   = 16'h0023;
   localparam logic [15:0] STAT_OPER_EN    = 16'h0027;
   localparam logic [15:0] STAT_FAULT_REAC = 16'h000f;
   localparam logic [15:0] STAT_FAULT      = 16'h0008;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int INIT_TIME_US  = 10;
   localparam int INIT_CYCLES   = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int REACT_TIME_US = 10;
   localparam int REACT_CYCLES  = (REACT_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int SYNC_PERIOD_1MS = 1;
   localparam int SYNC_PERIOD_2MS = 2;
   localparam int SYNC_PERIOD_4MS = 4;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_NOT_READY,
      ST_SW_ON_DIS,
      ST_READY,
      ST_SWITCHED,
      ST_OPER_EN,
      ST_FAULT_REAC,
      ST_FAULT
   } dsa_state_e;

   typedef struct packed {
      logic        toggle_err;
      logic        timeout;
      logic        cmd_unknown;
      logic        complete_req;
      logic        no_complete;
      logic        no_object;
      logic        no_sub;
      logic        sub0_required;
      logic        sub0_nonzero;
      logic        map_req;
      logic        not_mappable;
      logic        map_exceeds;
      logic        len_err;
      logic        len_long;
      logic        len_short;
      logic        too_great;
      logic        too_small;
      logic        below_min;
      logic        local_ctrl;
      logic        state_locked;
      logic        other_err;
   } dsa_check_s;

endpackage

// File: dsa_sync_master.sv
// sync pulse source standing in for the network master
// assumes one clock domain; one ms is scaled to MS_CYCLES clock cycles
`timescale 1ns/100ps
`default_nettype none

module dsa_sync_master #(
   parameter int MS_CYCLES = 8
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // programmed period and pulse
   input  wire logic [2:0] period_ms_i,
   output logic            sync_pulse_o
);
   // ==========================================================
   // shared system time and pulse
   logic [15:0] sys_time;
   logic [15:0] next_sys_time;
   logic [15:0] span;
   logic        next_sync_pulse;

   always_comb begin
      next_sys_time = sys_time + 16'h0001;
      span = 16'(period_ms_i) * 16'(MS_CYCLES);
      // two-cycle pulse at each period boundary of system time
      next_sync_pulse = (span != 16'h0000) &&
                        ((sys_time % span) < 16'h0002);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_time <= 16'h0000;
         sync_pulse_o <= 1'b0;
      end else begin
         sys_time <= next_sys_time;
         sync_pulse_o <= next_sync_pulse;
      end
   end
endmodule

`default_nettype wire

// File: dsa_top.sv
// drive power-stage state machine, status word, mailbox abort coder
// and sync-aligned control cycle strobe
// assumes an object access engine presents checks as a one-cycle request
// and a sync pulse from the clock unit, possibly asynchronous
//
// Functional notes
// - a failed object access returns a 32-bit code; zero means no error.
// - toggle error, timeout and unknown command each return their own code.
// - write refused when entry needs subindex zero cleared and it is not.
// - complete access to an object that forbids it is refused.
// - non-mappable object or oversize mapping each return their own code.
// - missing index and missing subindex each return their own code.
// - length mismatch, too long and too short return distinct codes.
// - above maximum, too small and below minimum values are refused.
// - state-locked and local-control access return distinct codes.
// - cycle interrupt is raised from the shared-time sync pulse.
// - control cycle aligns to master sync pulses in synchronous mode.
// - master commands via command word; device reports state in status word.
// - switch-on and enable-operation occur only on master command.
// - bits 0, 1 and 3 together from ready advance to operation enabled when main power is on.
// - sit in not-ready during initialization, then go to switch-on-disabled.
// - ready-to-switch-on keeps drive functions disabled with main power on.
// - switched-on is servo-on but drive functions stay disabled.
// - drive functions and torque only in operation enabled.
// - fault enters fault reaction on its own, then rests in fault.
// - parameter writes accepted in every state after initialization.
// - status bits 6,5,3,2,1,0 encode the state as tabulated.
// - rising fault-reset edge leaves fault toward switch-on-disabled.
`timescale 1ns/100ps
`default_nettype none

module dsa_top
   import dsa_pkg::*;
#(
   parameter int INIT_COUNT  = INIT_CYCLES,
   parameter int REACT_COUNT = REACT_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // command word and fault input
   input  wire logic [15:0] command_word_i,
   input  wire logic        command_valid_i,
   input  wire logic        fault_detect_i,
   input  wire logic        main_power_i,
   // object access check request
   input  wire logic        access_req_i,
   input  wire logic        access_write_i,
   input  wire dsa_check_s  access_check_i,
   // sync pulse and configured period
   input  wire logic        sync_pulse_i,
   input  wire logic        dc_mode_i,
   input  wire logic [2:0]  sync_period_ms_i,
   // access answer
   output logic             access_done_o,
   output logic             access_ok_o,
   output logic             param_write_o,
   output logic [31:0]      abort_code_o,
   // state and drive outputs
   output logic [15:0]      status_word_o,
   output dsa_state_e       state_o,
   output logic             servo_on_o,
   output logic             drive_enable_o,
   // cycle outputs
   output logic             cycle_irq_o,
   output logic             period_valid_o
);

   if (INIT_COUNT < 1 || REACT_COUNT < 1) begin : g_bad_count
      $error("dsa_top: counts must be at least one");
   end

   // ==========================================================
   // abort code priority encoder
   function automatic logic [31:0] abort_of(input dsa_check_s c,
                                            input logic       wr);
      logic [31:0] code;
      code = ABORT_NONE;
      if (c.toggle_err)
         code = ABORT_TOGGLE;
      else if (c.timeout)
         code = ABORT_TIMEOUT;
      else if (c.cmd_unknown)
         code = ABORT_CMD_UNKNOWN;
      else if (c.no_object)
         code = ABORT_NO_OBJECT;
      else if (c.no_sub)
         code = ABORT_NO_SUB;
      else if (c.complete_req && c.no_complete)
         code = ABORT_NO_COMPLETE;
      else if (c.local_ctrl)
         code = ABORT_LOCAL_CTRL;
      else if (c.state_locked)
         code = ABORT_STATE;
      else if (wr && c.sub0_required && c.sub0_nonzero)
         code = ABORT_SUB0_NZ;
      else if (wr && c.map_req && c.not_mappable)
         code = ABORT_NOT_MAPPABLE;
      else if (wr && c.map_req && c.map_exceeds)
         code = ABORT_MAP_EXCEEDS;
      else if (c.len_long)
         code = ABORT_LEN_LONG;
      else if (c.len_short)
         code = ABORT_LEN_SHORT;
      else if (c.len_err)
         code = ABORT_LEN;
      else if (wr && c.too_great)
         code = ABORT_TOO_GREAT;
      else if (wr && c.below_min)
         code = ABORT_BELOW_MIN;
      else if (wr && c.too_small)
         code = ABORT_TOO_SMALL;
      else if (c.other_err)
         code = ABORT_GENERAL;
      return code;
   endfunction

   // ==========================================================
   // input synchronisers for the sync pulse
   logic sync_meta;
   logic sync_sync;
   logic sync_prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_meta <= 1'b0;
         sync_sync <= 1'b0;
         sync_prev <= 1'b0;
      end else begin
         sync_meta <= sync_pulse_i;
         sync_sync <= sync_meta;
         sync_prev <= sync_sync;
      end
   end

   // ==========================================================
   // drive state machine
   dsa_state_e  state;
   dsa_state_e  next_state;
   logic [31:0] count;
   logic [31:0] next_count;
   logic        fr_prev;
   logic        next_fr_prev;
   logic        fr_rise;
   logic        sw_on;
   logic        en_volt;
   logic        en_oper;

   always_comb begin
      sw_on        = command_word_i[CMD_SWITCH_ON];
      en_volt      = command_word_i[CMD_EN_VOLTAGE];
      en_oper      = command_word_i[CMD_EN_OPER];
      fr_rise      = command_valid_i && command_word_i[CMD_FAULT_RESET]
                     && !fr_prev;
      next_fr_prev = command_valid_i ? command_word_i[CMD_FAULT_RESET]
                                     : fr_prev;
      next_state   = state;
      next_count   = count;
      if (fault_detect_i && state != ST_NOT_READY && state != ST_FAULT_REAC
          && state != ST_FAULT) begin
         next_state = ST_FAULT_REAC;
         next_count = 32'h0000_0000;
      end else begin
         unique case (state)
            ST_NOT_READY: begin
               if (count >= 32'(INIT_COUNT - 1)) begin
                  next_state = ST_SW_ON_DIS;
                  next_count = 32'h0000_0000;
               end else begin
                  next_count = count + 32'h0000_0001;
               end
            end
            ST_SW_ON_DIS: begin
               // quick-stop bit is ignored: quick stop not supported
               if (command_valid_i && en_volt && !sw_on)
                  next_state = ST_READY;
            end
            ST_READY: begin
               if (command_valid_i) begin
                  if (!en_volt)
                     next_state = ST_SW_ON_DIS;
                  else if (sw_on && en_oper && main_power_i)
                     next_state = ST_OPER_EN;
                  else if (sw_on && main_power_i)
                     next_state = ST_SWITCHED;
               end
            end
            ST_SWITCHED: begin
               if (command_valid_i) begin
                  if (!en_volt)
                     next_state = ST_SW_ON_DIS;
                  else if (!sw_on)
                     next_state = ST_READY;
                  else if (en_oper)
                     next_state = ST_OPER_EN;
               end
            end
            ST_OPER_EN: begin
               if (command_valid_i) begin
                  if (!en_volt)
                     next_state = ST_SW_ON_DIS;
                  else if (!sw_on)
                     next_state = ST_READY;
                  else if (!en_oper)
                     next_state = ST_SWITCHED;
               end
            end
            ST_FAULT_REAC: begin
               if (count >= 32'(REACT_COUNT - 1)) begin
                  next_state = ST_FAULT;
                  next_count = 32'h0000_0000;
               end else begin
                  next_count = count + 32'h0000_0001;
               end
            end
            ST_FAULT: begin
               if (fr_rise && !fault_detect_i)
                  next_state = ST_SW_ON_DIS;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ST_NOT_READY;
         count   <= 32'h0000_0000;
         fr_prev <= 1'b0;
      end else begin
         state   <= next_state;
         count   <= next_count;
         fr_prev <= next_fr_prev;
      end
   end

   // ==========================================================
   // status word and drive outputs
   logic [15:0] next_status;
   logic        next_servo;
   logic        next_drive;

   always_comb begin
      next_servo = 1'b0;
      next_drive = 1'b0;
      next_status = STAT_NOT_READY;
      unique case (next_state)
         ST_NOT_READY:  next_status = STAT_NOT_READY;
         ST_SW_ON_DIS:  next_status = STAT_SW_ON_DIS;
         ST_READY:      next_status = STAT_READY;
         ST_SWITCHED: begin
            next_status = STAT_SWITCHED;
            next_servo  = 1'b1;
         end
         ST_OPER_EN: begin
            next_status = STAT_OPER_EN;
            next_servo  = 1'b1;
            next_drive  = 1'b1;
         end
         ST_FAULT_REAC: next_status = STAT_FAULT_REAC;
         ST_FAULT:      next_status = STAT_FAULT;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_word_o  <= STAT_NOT_READY;
         servo_on_o     <= 1'b0;
         drive_enable_o <= 1'b0;
      end else begin
         status_word_o  <= next_status;
         servo_on_o     <= next_servo;
         drive_enable_o <= next_drive;
      end
   end

   assign state_o = state;

   // ==========================================================
   // object access answer
   logic        next_done;
   logic        next_ok;
   logic        next_pwrite;
   logic [31:0] next_abort;
   logic [31:0] code_now;

   always_comb begin
      code_now    = abort_of(access_check_i, access_write_i);
      next_done   = 1'b0;
      next_ok     = 1'b0;
      next_pwrite = 1'b0;
      next_abort  = abort_code_o;
      if (access_req_i) begin
         next_done = 1'b1;
         if (state == ST_NOT_READY) begin
            next_abort = ABORT_STATE;
         end else begin
            next_abort  = code_now;
            next_ok     = (code_now == ABORT_NONE);
            next_pwrite = access_write_i && (code_now == ABORT_NONE);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         access_done_o <= 1'b0;
         access_ok_o   <= 1'b0;
         param_write_o <= 1'b0;
         abort_code_o  <= ABORT_NONE;
      end else begin
         access_done_o <= next_done;
         access_ok_o   <= next_ok;
         param_write_o <= next_pwrite;
         abort_code_o  <= next_abort;
      end
   end

   // ==========================================================
   // sync-aligned cycle strobe
   logic next_irq;
   logic next_pvalid;

   always_comb begin
      next_pvalid = (sync_period_ms_i == 3'(SYNC_PERIOD_1MS))
                 || (sync_period_ms_i == 3'(SYNC_PERIOD_2MS))
                 || (sync_period_ms_i == 3'(SYNC_PERIOD_4MS));
      next_irq    = dc_mode_i && next_pvalid
                    && sync_sync && !sync_prev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cycle_irq_o    <= 1'b0;
         period_valid_o <= 1'b0;
      end else begin
         cycle_irq_o    <= next_irq;
         period_valid_o <= next_pvalid;
      end
   end

endmodule

`default_nettype wire

// File: dsa_top_sva.sv
// port-level checks for dsa_top
// assumes the ports of dsa_top only; bound below
`timescale 1ns/100ps
`default_nettype none

module dsa_top_sva
   import dsa_pkg::*;
#(
   parameter int INIT_COUNT  = INIT_CYCLES,
   parameter int REACT_COUNT = REACT_CYCLES
) (
   // clock, reset, command
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [15:0] command_word_i,
   input wire logic        command_valid_i,
   input wire logic        fault_detect_i,
   input wire logic        main_power_i,
   // access and sync inputs
   input wire logic        access_req_i,
   input wire logic        access_write_i,
   input wire dsa_check_s  access_check_i,
   input wire logic        sync_pulse_i,
   input wire logic        dc_mode_i,
   input wire logic [2:0]  sync_period_ms_i,
   // outputs watched
   input wire logic        access_done_o,
   input wire logic        access_ok_o,
   input wire logic        param_write_o,
   input wire logic [31:0] abort_code_o,
   input wire logic [15:0] status_word_o,
   input wire dsa_state_e  state_o,
   input wire logic        servo_on_o,
   input wire logic        drive_enable_o,
   input wire logic        cycle_irq_o,
   input wire logic        period_valid_o
);
   // ==========================================================
   // helpers
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic        live;
   logic [15:0] exp_stat;
   assign live = (state_o != ST_NOT_READY);
   always_comb begin
      case (state_o)
         ST_SW_ON_DIS:  exp_stat = STAT_SW_ON_DIS;
         ST_READY:      exp_stat = STAT_READY;
         ST_SWITCHED:   exp_stat = STAT_SWITCHED;
         ST_OPER_EN:    exp_stat = STAT_OPER_EN;
         ST_FAULT_REAC: exp_stat = STAT_FAULT_REAC;
         ST_FAULT:      exp_stat = STAT_FAULT;
         default:       exp_stat = STAT_NOT_READY;
      endcase
   end

   // ==========================================================
   // assertions
   done_answer_a:
      assert property (access_req_i |=> access_done_o)
      else $error("access not answered");
   ok_code_a:
      assert property (access_done_o |-> access_ok_o == (abort_code_o == 0))
      else $error("ok flag disagrees with code");
   toggle_code_a:
      assert property (access_req_i && live && access_check_i.toggle_err
                       |=> abort_code_o == ABORT_TOGGLE)
      else $error("toggle code wrong");
   no_object_a:
      assert property (access_req_i && live && access_check_i.no_object &&
                       !access_check_i.toggle_err && !access_check_i.timeout
                       && !access_check_i.cmd_unknown
                       |=> abort_code_o == ABORT_NO_OBJECT)
      else $error("missing object code wrong");
   write_ok_a:
      assert property (access_done_o |->
                       param_write_o == (access_ok_o && $past(access_write_i)))
      else $error("parameter write flag wrong");
   drive_only_a:
      assert property (drive_enable_o |-> state_o == ST_OPER_EN)
      else $error("drive enabled outside operation");
   servo_state_a:
      assert property (servo_on_o == (state_o inside {ST_SWITCHED, ST_OPER_EN}))
      else $error("servo flag wrong");
   status_map_a:
      assert property (status_word_o == exp_stat)
      else $error("status word wrong");
   fault_entry_a:
      assert property (fault_detect_i && state_o inside {ST_SW_ON_DIS,
                       ST_READY, ST_SWITCHED, ST_OPER_EN}
                       |=> state_o == ST_FAULT_REAC && !drive_enable_o)
      else $error("fault not entered");
   no_self_a:
      assert property (state_o inside {ST_READY, ST_SWITCHED, ST_OPER_EN} &&
                       !command_valid_i && !fault_detect_i |=> $stable(state_o))
      else $error("state moved without command");
   irq_align_a:
      assert property ($rose(sync_pulse_i) ##2 (dc_mode_i &&
                       sync_period_ms_i inside {3'h1, 3'h2, 3'h4})
                       |=> cycle_irq_o)
      else $error("cycle strobe not aligned");
   irq_pulse_a:
      assert property (cycle_irq_o |=> !cycle_irq_o)
      else $error("cycle strobe too long");
   period_valid_a:
      assert property (1'b1 |=> period_valid_o ==
                       ($past(sync_period_ms_i) inside {3'h1, 3'h2, 3'h4}))
      else $error("period check wrong");

   cover property (state_o == ST_OPER_EN);
   cover property (state_o == ST_FAULT);
   cover property (cycle_irq_o);
   cover property (access_done_o && !access_ok_o);
endmodule

bind dsa_top dsa_top_sva #(
   .INIT_COUNT(INIT_COUNT),
   .REACT_COUNT(REACT_COUNT)
) dsa_top_sva_inst (
   .clk_i, .rst_i, .command_word_i, .command_valid_i, .fault_detect_i,
   .main_power_i, .access_req_i, .access_write_i, .access_check_i,
   .sync_pulse_i, .dc_mode_i, .sync_period_ms_i, .access_done_o,
   .access_ok_o, .param_write_o, .abort_code_o, .status_word_o, .state_o,
   .servo_on_o, .drive_enable_o, .cycle_irq_o, .period_valid_o
);

`default_nettype wire

// File: tb.sv
// self-checking bench for dsa_top with a sync source model
// assumes dsa_pkg, dsa_top, dsa_sync_master and the bound checker
`timescale 1ns/100ps
`default_nettype none

module tb;
   import dsa_pkg::*;
   // ==========================================================
   // tables and signals
   typedef struct packed {logic [20:0] m; logic [31:0] c;} dsa_arow_s;
   typedef struct packed {logic [15:0] w; logic [15:0] s;} dsa_crow_s;
   localparam int LEN = 4;
   localparam dsa_arow_s AROWS [19] = '{
      '{21'h100000, ABORT_TOGGLE}, '{21'h080000, ABORT_TIMEOUT},
      '{21'h040000, ABORT_CMD_UNKNOWN}, '{21'h030000, ABORT_NO_COMPLETE},
      '{21'h008000, ABORT_NO_OBJECT}, '{21'h004000, ABORT_NO_SUB},
      '{21'h003000, ABORT_SUB0_NZ}, '{21'h000c00, ABORT_NOT_MAPPABLE},
      '{21'h000a00, ABORT_MAP_EXCEEDS}, '{21'h000100, ABORT_LEN},
      '{21'h000080, ABORT_LEN_LONG}, '{21'h000040, ABORT_LEN_SHORT},
      '{21'h000020, ABORT_TOO_GREAT}, '{21'h000010, ABORT_TOO_SMALL},
      '{21'h000008, ABORT_BELOW_MIN}, '{21'h000004, ABORT_LOCAL_CTRL},
      '{21'h000002, ABORT_STATE}, '{21'h000001, ABORT_GENERAL},
      '{21'h000000, ABORT_NONE}};
   localparam dsa_crow_s CROWS [8] = '{
      '{16'h0006, STAT_READY}, '{16'h0007, STAT_SWITCHED},
      '{16'h000f, STAT_OPER_EN}, '{16'h0007, STAT_SWITCHED},
      '{16'h0006, STAT_READY}, '{16'h0000, STAT_SW_ON_DIS},
      '{16'h0006, STAT_READY}, '{16'h000f, STAT_OPER_EN}};
   logic        clk, rst, cmd_valid, fault, power, req, wr, dc_mode, sync;
   logic        done, ok, pwr_wr, servo, drive, irq, pvalid;
   logic [15:0] cmd_word, stat;
   logic [2:0]  period;
   logic [31:0] code;
   dsa_check_s  chk;
   dsa_state_e  state;
   int          errors, samples_checked, cycles, irq_cnt, i, gap, n0;

   dsa_top #(.INIT_COUNT(LEN), .REACT_COUNT(LEN)) dsa_top_inst (
      .clk_i(clk), .rst_i(rst), .command_word_i(cmd_word),
      .command_valid_i(cmd_valid), .fault_detect_i(fault),
      .main_power_i(power), .access_req_i(req), .access_write_i(wr),
      .access_check_i(chk), .sync_pulse_i(sync), .dc_mode_i(dc_mode),
      .sync_period_ms_i(period), .access_done_o(done), .access_ok_o(ok),
      .param_write_o(pwr_wr), .abort_code_o(code), .status_word_o(stat),
      .state_o(state), .servo_on_o(servo), .drive_enable_o(drive),
      .cycle_irq_o(irq), .period_valid_o(pvalid));
   dsa_sync_master #(.MS_CYCLES(8)) dsa_sync_master_inst (
      .clk_i(clk), .rst_i(rst), .period_ms_i(period), .sync_pulse_o(sync));

   // ==========================================================
   // tasks
   task automatic compare(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic command(input logic [15:0] w);
      @(posedge clk);
      cmd_word <= w;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
   endtask
   task automatic access(input logic [20:0] m, input logic w);
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      chk <= dsa_check_s'(m);
      @(posedge clk);
      req <= 1'b0;
      #1;
   endtask
   task automatic irq_gap();
      #1;
      for (int k = 0; k < 200 && irq !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      gap = 0;
      do begin
         @(posedge clk);
         #1;
         gap++;
      end while (irq !== 1'b1 && gap < 200);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // clock, timeout, strobe count
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (irq === 1'b1)
         irq_cnt++;
      if (cycles == 5000) begin
         errors++;
         stop_test();
      end
   end

   // ==========================================================
   // sequence
   initial begin
      {clk, cmd_valid, fault, req, wr, dc_mode} = '0;
      {errors, samples_checked, cycles, irq_cnt} = '0;
      rst = 1'b1;
      power = 1'b1;
      cmd_word = 16'h0000;
      chk = '0;
      period = 3'h1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      access(21'h000000, 1'b1);
      compare(ABORT_STATE, code);
      compare(STAT_NOT_READY, stat);
      repeat (LEN) @(posedge clk);
      #1;
      compare(STAT_SW_ON_DIS, stat);
      $display("init test done");
      for (i = 0; i < 19; i++) begin
         access(AROWS[i].m, 1'b1);
         compare(AROWS[i].c, code);
         compare(32'h1, 32'(done));
         compare(32'(AROWS[i].c == 0), 32'(ok));
         compare(32'(AROWS[i].c == 0), 32'(pwr_wr));
      end
      access(21'h003020, 1'b0);
      compare(ABORT_NONE, code);
      $display("abort table done");
      for (i = 0; i < 8; i++) begin
         command(CROWS[i].w);
         compare(32'(CROWS[i].s), 32'(stat));
         compare(32'(CROWS[i].s == STAT_OPER_EN), 32'(drive));
         compare(32'(CROWS[i].s[1]), 32'(servo));
      end
      repeat (10) @(posedge clk);
      access(21'h000000, 1'b1);
      compare(STAT_OPER_EN, stat);
      compare(32'h1, 32'(pwr_wr));
      $display("command test done");
      @(posedge clk);
      fault <= 1'b1;
      @(posedge clk);
      fault <= 1'b0;
      #1;
      compare(STAT_FAULT_REAC, stat);
      compare(32'h0, 32'(drive));
      repeat (LEN + 2) @(posedge clk);
      power <= 1'b0;
      #1;
      compare(STAT_FAULT, stat);
      command(16'h0006);
      compare(STAT_FAULT, stat);
      command(16'h0080);
      compare(STAT_SW_ON_DIS, stat);
      command(16'h0000);
      command(16'h0006);
      command(16'h0007);
      compare(STAT_READY, stat);
      $display("fault test done");
      @(posedge clk);
      dc_mode <= 1'b1;
      for (i = 0; i < 3; i++) begin
         @(posedge clk);
         period <= 3'(1 << i);
         repeat (80) @(posedge clk);
         irq_gap();
         compare(32'(8 << i), 32'(gap));
      end
      @(posedge clk);
      period <= 3'h3;
      repeat (10) @(posedge clk);
      n0 = irq_cnt;
      repeat (60) @(posedge clk);
      compare(32'h0, 32'(pvalid));
      compare(32'(n0), 32'(irq_cnt));
      period <= 3'h1;
      dc_mode <= 1'b0;
      repeat (10) @(posedge clk);
      n0 = irq_cnt;
      repeat (60) @(posedge clk);
      compare(32'(n0), 32'(irq_cnt));
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1;
      compare(STAT_NOT_READY, stat);
      $display("sync test done");
      stop_test();
   end
endmodule

`default_nettype wire
